// *** logic/stl_pkg.sv ***
package stl_pkg;
    // trigger list storage
    localparam int LIST_MAX = 80;
    localparam int LEN_W = 7;

    // enable register select codes
    localparam int EN_NUM = 5;
    localparam logic [2:0] EN_SEL_STD = 3'h0;
    localparam logic [2:0] EN_SEL_A = 3'h1;
    localparam logic [2:0] EN_SEL_B = 3'h2;
    localparam logic [2:0] EN_SEL_SRQ = 3'h3;
    localparam logic [2:0] EN_SEL_PP = 3'h4;

    // event / status query select codes
    localparam logic [1:0] EVT_SEL_STD = 2'h0;
    localparam logic [1:0] EVT_SEL_A = 2'h1;
    localparam logic [1:0] EVT_SEL_B = 2'h2;
    localparam logic [1:0] EVT_SEL_STB = 2'h3;

    // field positions
    localparam int ESR_EXE_BIT = 4;
    localparam int ERB_LIST_ERR_BIT = 3;
    localparam int STB_ERA_BIT = 0;
    localparam int STB_ERB_BIT = 1;
    localparam int STB_MAV_BIT = 4;
    localparam int STB_ESB_BIT = 5;
    localparam int STB_RQS_BIT = 6;

    // reset values
    localparam logic [7:0] EN_RESET = 8'h00;
    localparam logic [7:0] EVT_RESET = 8'h00;
    localparam logic PSC_RESET = 1'b0;

    // characters
    localparam logic [7:0] CHAR_SLASH = 8'h2F;
    localparam logic [7:0] CHAR_SEMI = 8'h3B;
    localparam logic [7:0] CHAR_SPACE = 8'h20;
    localparam logic [7:0] CHAR_STAR = 8'h2A;
    localparam logic [7:0] CHAR_T = 8'h54;
    localparam logic [7:0] CHAR_R = 8'h52;
    localparam logic [7:0] CHAR_G = 8'h47;
    localparam logic [7:0] CASE_FOLD = 8'hDF;

    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_PLAY, ST_READ} stl_state_t;
endpackage

// *** logic/stl_list_if.sv ***
`timescale 1ns/1ns
interface stl_list_if #(parameter int LEN_W = stl_pkg::LEN_W);
    logic clear;
    logic wr_start;
    logic wr_valid;
    logic [7:0] wr_char;
    logic ovf;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] rd_addr;
    logic [7:0] rd_char;

    modport store (
        input clear, wr_start, wr_valid, wr_char, rd_addr,
        output ovf, len, rd_char
    );
    modport ctrl (
        output clear, wr_start, wr_valid, wr_char, rd_addr,
        input ovf, len, rd_char
    );
endinterface

// *** logic/stl_list_store.sv ***
`timescale 1ns/1ns
module stl_list_store #(
    parameter int DEPTH = stl_pkg::LIST_MAX,
    parameter int LEN_W = stl_pkg::LEN_W
) (
    input wire logic clk_i,      // system clock
    input wire logic rst_n_i,    // async reset, active low
    stl_list_if.store lst        // list access from the controller
);
    logic [7:0] mem [DEPTH];
    logic [LEN_W-1:0] len_r;
    logic [LEN_W-1:0] len_nxt;
    logic [LEN_W-1:0] len_base;
    logic full;
    logic wr_ok;

    // a new definition restarts the list; a device reset empties it
    assign len_base = (lst.clear || lst.wr_start) ? '0 : len_r; // R7
    assign full = (len_base == LEN_W'(DEPTH));
    // accepted unchecked; characters past the limit are dropped
    assign wr_ok = lst.wr_valid && !full && !lst.clear; // R4 R11
    assign lst.ovf = lst.wr_valid && full && !lst.clear; // R10
    assign len_nxt = wr_ok ? len_base + LEN_W'(1) : len_base;
    assign lst.len = len_r;
    assign lst.rd_char = mem[lst.rd_addr];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            len_r <= '0; // R7
        end else begin
            len_r <= len_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (wr_ok) begin
            mem[len_base] <= lst.wr_char;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_list_bound: assert property ( // R4
        len_r <= LEN_W'(DEPTH)
    ) else $error("trigger list longer than its capacity");

    a_ovf_drop: assert property ( // R10
        (lst.ovf && !lst.wr_start && !lst.clear) |=> (len_r == LEN_W'(DEPTH))
    ) else $error("overflowing character changed the list length");
endmodule

// *** logic/stl_status_top.sv ***
`timescale 1ns/1ns
//
// Summary of operation
// R1: clear-status zeroes events and status, keeps message-available; here the request bit stays too if message-available is request-enabled
// R2: clear-status withdraws any pending service request; here a request from message-available stays if that bit is request-enabled
// R3: clear-status leaves enables and settings untouched
// R4: trigger list holds up to 80 characters
// R5: trigger or group-execute runs the stored list
// R6: slashes separate commands, read back as semicolons
// R7: power-on and device reset empty the list
// R8: empty list reads back as one space
// R9: trigger inside list flags execution and list errors
// R10: overlong list drops surplus, flags execution error
// R11: list stored unchecked, checked only on trigger
// R12: faulty list stays readable, errors every trigger
// R13: running the list never alters it
// R14: group message true while any enabled bit true
// R15: enable masks gate service request and status
// R16: five separate 8-bit readable writable enable registers
// R17: enables change only on explicit write
// R18: enables survive power-off, cleared only with flag
// R19: message-available is status bit 4
// R20: reading an event register clears it
// R21: trigger with empty list does nothing, no error
module stl_status_top (
    input wire logic SYS_CLK_I,               // system clock, 250 MHz
    input wire logic RESET_N_I,               // power-on reset, active low
    input wire logic DEV_RST_I,               // device reset command pulse
    input wire logic CLS_I,                   // clear-status command pulse
    input wire logic [7:0] EVT_SET_STD_I,     // standard event set pulses
    input wire logic [7:0] EVT_SET_A_I,       // event register A set pulses
    input wire logic [7:0] EVT_SET_B_I,       // event register B set pulses
    input wire logic MAV_I,                   // response waiting in output buffer
    input wire logic EVT_RD_I,                // event/status query pulse
    input wire logic [1:0] EVT_SEL_I,         // which event register or status byte
    input wire logic EN_WR_I,                 // enable register write pulse
    input wire logic EN_RD_I,                 // enable register query pulse
    input wire logic [2:0] EN_SEL_I,          // which enable register
    input wire logic [7:0] EN_DATA_I,         // enable write value
    input wire logic PSC_WR_I,                // poweroff clear flag write pulse
    input wire logic PSC_DATA_I,              // poweroff clear flag value
    input wire logic NV_RESTORE_I,            // load non-volatile copy pulse
    input wire logic [39:0] NV_ENABLES_I,     // saved enables, five bytes
    input wire logic NV_PSC_I,                // saved poweroff clear flag
    input wire logic SHUTDOWN_I,              // shutdown pulse
    input wire logic DEF_START_I,             // trigger list define start pulse
    input wire logic DEF_VALID_I,             // trigger list character strobe
    input wire logic [7:0] DEF_CHAR_I,        // trigger list character
    input wire logic TRIG_I,                  // trigger command or group execute
    input wire logic LIST_RD_I,               // trigger list query pulse
    input wire logic EXEC_READY_I,            // parser takes execution character
    input wire logic RB_READY_I,              // output buffer takes read-back char
    output logic [7:0] RD_DATA_O,             // query answer
    output logic RD_VALID_O,                  // query answer strobe
    output logic [7:0] STB_O,                 // live status byte
    output logic SRQ_O,                       // service request level
    output logic IST_O,                       // individual status message
    output logic PSC_O,                       // poweroff clear flag
    output logic [39:0] NV_ENABLES_O,         // enables for non-volatile copy
    output logic EXEC_VALID_O,                // execution character valid
    output logic [7:0] EXEC_CHAR_O,           // execution character
    output logic EXEC_LAST_O,                 // last execution character
    output logic RB_VALID_O,                  // read-back character valid
    output logic [7:0] RB_CHAR_O,             // read-back character
    output logic RB_LAST_O,                   // last read-back character
    output logic TRIG_DONE_O,                 // trigger finished pulse
    output logic LIST_BUSY_O                  // list engine busy
);
    localparam int LEN_W = stl_pkg::LEN_W;
    localparam logic [7:0] EXE_MASK = 8'h01 << stl_pkg::ESR_EXE_BIT;
    localparam logic [7:0] LERR_MASK = 8'h01 << stl_pkg::ERB_LIST_ERR_BIT;

    function automatic logic [7:0] evt_next(input logic [7:0] cur, input logic [7:0] set, input logic clr);
        return set | (clr ? 8'h00 : cur);
    endfunction

    function automatic logic pat_hit(input logic [1:0] m, input logic [7:0] ch);
        logic h;
        h = 1'b0;
        case (m)
            2'h0: h = (ch == stl_pkg::CHAR_STAR);
            2'h1: h = ((ch & stl_pkg::CASE_FOLD) == stl_pkg::CHAR_T);
            2'h2: h = ((ch & stl_pkg::CASE_FOLD) == stl_pkg::CHAR_R);
            default: h = ((ch & stl_pkg::CASE_FOLD) == stl_pkg::CHAR_G);
        endcase
        return h;
    endfunction

    stl_list_if #(.LEN_W(LEN_W)) lst ();

    stl_list_store #(.DEPTH(stl_pkg::LIST_MAX), .LEN_W(LEN_W)) u_store (
        .clk_i(SYS_CLK_I),
        .rst_n_i(RESET_N_I),
        .lst(lst)
    );

    // enable registers: restore, then shutdown clear, then write
    logic [7:0] en_r [stl_pkg::EN_NUM];
    logic psc_r;
    logic en_clr;

    assign en_clr = SHUTDOWN_I && psc_r; // R18

    for (genvar k = 0; k < stl_pkg::EN_NUM; k++) begin : g_en
        logic hit;
        logic [7:0] en_nxt;
        assign hit = EN_WR_I && (EN_SEL_I == 3'(k)); // R16
        assign en_nxt = NV_RESTORE_I ? NV_ENABLES_I[k*8 +: 8] :
                        en_clr ? stl_pkg::EN_RESET :
                        hit ? EN_DATA_I : en_r[k]; // R17 R18
        assign NV_ENABLES_O[k*8 +: 8] = en_r[k];
        always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
            if (!RESET_N_I) begin
                en_r[k] <= stl_pkg::EN_RESET;
            end else begin
                en_r[k] <= en_nxt;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            psc_r <= stl_pkg::PSC_RESET;
        end else if (NV_RESTORE_I) begin
            psc_r <= NV_PSC_I;
        end else if (PSC_WR_I) begin
            psc_r <= PSC_DATA_I;
        end
    end
    assign PSC_O = psc_r;

    // event registers, set wins over clear
    logic [7:0] esr_r;
    logic [7:0] era_r;
    logic [7:0] erb_r;
    logic list_err;
    logic [7:0] esr_set;
    logic [7:0] erb_set;
    logic no_evt_set;

    assign esr_set = EVT_SET_STD_I | ((list_err || lst.ovf) ? EXE_MASK : 8'h00); // R9 R10 R12
    assign erb_set = EVT_SET_B_I | (list_err ? LERR_MASK : 8'h00); // R9
    assign no_evt_set = (esr_set == 8'h00) && (EVT_SET_A_I == 8'h00) && (erb_set == 8'h00);

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            esr_r <= stl_pkg::EVT_RESET;
            era_r <= stl_pkg::EVT_RESET;
            erb_r <= stl_pkg::EVT_RESET;
        end else begin
            esr_r <= evt_next(esr_r, esr_set, CLS_I || (EVT_RD_I && EVT_SEL_I == stl_pkg::EVT_SEL_STD)); // R1 R20
            era_r <= evt_next(era_r, EVT_SET_A_I, CLS_I || (EVT_RD_I && EVT_SEL_I == stl_pkg::EVT_SEL_A)); // R1 R20
            erb_r <= evt_next(erb_r, erb_set, CLS_I || (EVT_RD_I && EVT_SEL_I == stl_pkg::EVT_SEL_B)); // R1 R20
        end
    end

    // status byte is derived, so clearing the events clears all of it but message-available and, with its service request enable bit set, the request bit
    logic [7:0] stb_base;
    logic rqs;
    always_comb begin
        stb_base = 8'h00;
        stb_base[stl_pkg::STB_ERA_BIT] = |(era_r & en_r[stl_pkg::EN_SEL_A]); // R14
        stb_base[stl_pkg::STB_ERB_BIT] = |(erb_r & en_r[stl_pkg::EN_SEL_B]); // R14
        stb_base[stl_pkg::STB_MAV_BIT] = MAV_I; // R19 R1
        stb_base[stl_pkg::STB_ESB_BIT] = |(esr_r & en_r[stl_pkg::EN_SEL_STD]); // R14
    end
    assign rqs = |(stb_base & en_r[stl_pkg::EN_SEL_SRQ]); // R15 R2
    assign STB_O = stb_base | (rqs ? (8'h01 << stl_pkg::STB_RQS_BIT) : 8'h00);
    assign SRQ_O = rqs; // R14 R15
    assign IST_O = |(STB_O & en_r[stl_pkg::EN_SEL_PP]); // R14 R15

    // query answers
    logic [7:0] evt_val;
    logic [7:0] en_val;
    logic [7:0] rd_data_r;
    logic rd_valid_r;
    assign evt_val = (EVT_SEL_I == stl_pkg::EVT_SEL_STD) ? esr_r :
                     (EVT_SEL_I == stl_pkg::EVT_SEL_A) ? era_r :
                     (EVT_SEL_I == stl_pkg::EVT_SEL_B) ? erb_r : STB_O;
    assign en_val = (EN_SEL_I < 3'(stl_pkg::EN_NUM)) ? en_r[EN_SEL_I] : 8'h00;

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rd_data_r <= 8'h00;
            rd_valid_r <= 1'b0;
        end else begin
            rd_data_r <= EVT_RD_I ? evt_val : en_val;
            rd_valid_r <= EVT_RD_I || EN_RD_I;
        end
    end
    assign RD_DATA_O = rd_data_r;
    assign RD_VALID_O = rd_valid_r;

    // trigger list engine: scan for a nested trigger, then play; read back goes straight out without a scan
    stl_pkg::stl_state_t state_r, state_nxt;
    logic [LEN_W-1:0] idx_r, idx_nxt;
    logic [1:0] match_r, match_nxt;
    logic found_r, found_nxt;
    logic [7:0] out_char_r, out_char_nxt;
    logic out_vld_r, out_vld_nxt;
    logic out_last_r, out_last_nxt;
    logic done_nxt, done_r;
    logic idle;
    logic hit_now;
    logic found_now;
    logic at_last;
    logic more;
    logic ready_in;
    logic [7:0] ch_conv;

    assign idle = (state_r == stl_pkg::ST_IDLE);
    assign lst.clear = DEV_RST_I; // R7
    assign lst.wr_start = DEF_START_I && idle;
    assign lst.wr_valid = DEF_VALID_I && idle; // R11 R13
    assign lst.wr_char = DEF_CHAR_I;
    assign lst.rd_addr = idx_r;
    assign hit_now = pat_hit(match_r, lst.rd_char);
    assign found_now = found_r || (hit_now && match_r == 2'h3); // R9
    assign at_last = (idx_r == lst.len - LEN_W'(1));
    assign more = (idx_r < lst.len);
    assign ready_in = (state_r == stl_pkg::ST_PLAY) ? EXEC_READY_I : RB_READY_I;
    assign ch_conv = (lst.rd_char == stl_pkg::CHAR_SLASH) ? stl_pkg::CHAR_SEMI : lst.rd_char; // R6
    assign list_err = (state_r == stl_pkg::ST_SCAN) && at_last && found_now && !DEV_RST_I; // R9 R12

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        match_nxt = match_r;
        found_nxt = found_r;
        out_char_nxt = out_char_r;
        out_vld_nxt = out_vld_r;
        out_last_nxt = out_last_r;
        done_nxt = 1'b0;
        case (state_r)
            stl_pkg::ST_IDLE: begin
                idx_nxt = '0;
                match_nxt = 2'h0;
                found_nxt = 1'b0;
                if (TRIG_I) begin
                    if (lst.len == '0) begin
                        done_nxt = 1'b1; // R21
                    end else begin
                        state_nxt = stl_pkg::ST_SCAN; // R5 R11
                    end
                end else if (LIST_RD_I) begin
                    state_nxt = stl_pkg::ST_READ;
                    if (lst.len == '0) begin
                        out_char_nxt = stl_pkg::CHAR_SPACE; // R8
                        out_vld_nxt = 1'b1;
                        out_last_nxt = 1'b1;
                    end
                end
            end
            stl_pkg::ST_SCAN: begin
                idx_nxt = idx_r + LEN_W'(1);
                match_nxt = hit_now ? match_r + 2'h1 : ((lst.rd_char == stl_pkg::CHAR_STAR) ? 2'h1 : 2'h0);
                found_nxt = found_now;
                if (at_last) begin
                    idx_nxt = '0;
                    if (found_now) begin
                        state_nxt = stl_pkg::ST_IDLE; // R12
                        done_nxt = 1'b1;
                    end else begin
                        state_nxt = stl_pkg::ST_PLAY; // R5
                    end
                end
            end
            stl_pkg::ST_PLAY, stl_pkg::ST_READ: begin
                if (!out_vld_r || ready_in) begin
                    if (more) begin
                        out_char_nxt = ch_conv; // R6
                        out_vld_nxt = 1'b1;
                        out_last_nxt = at_last;
                        idx_nxt = idx_r + LEN_W'(1);
                    end else begin
                        out_vld_nxt = 1'b0;
                        out_last_nxt = 1'b0;
                        state_nxt = stl_pkg::ST_IDLE;
                        done_nxt = (state_r == stl_pkg::ST_PLAY);
                    end
                end
            end
            default: state_nxt = stl_pkg::ST_IDLE;
        endcase
        if (DEV_RST_I) begin
            state_nxt = stl_pkg::ST_IDLE;
            out_vld_nxt = 1'b0;
            out_last_nxt = 1'b0;
            done_nxt = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_r <= stl_pkg::ST_IDLE;
            idx_r <= '0;
            match_r <= 2'h0;
            found_r <= 1'b0;
            out_char_r <= 8'h00;
            out_vld_r <= 1'b0;
            out_last_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            match_r <= match_nxt;
            found_r <= found_nxt;
            out_char_r <= out_char_nxt;
            out_vld_r <= out_vld_nxt;
            out_last_r <= out_last_nxt;
            done_r <= done_nxt;
        end
    end

    assign EXEC_VALID_O = out_vld_r && (state_r == stl_pkg::ST_PLAY);
    assign EXEC_CHAR_O = out_char_r;
    assign EXEC_LAST_O = out_last_r;
    assign RB_VALID_O = out_vld_r && (state_r == stl_pkg::ST_READ);
    assign RB_CHAR_O = out_char_r;
    assign RB_LAST_O = out_last_r;
    assign TRIG_DONE_O = done_r;
    assign LIST_BUSY_O = !idle;

    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RESET_N_I);

    a_cls_events: assert property ( // R1
        (CLS_I && no_evt_set) |=> (esr_r == 8'h00 && era_r == 8'h00 && erb_r == 8'h00)
    ) else $error("clear-status left an event bit set");

    a_cls_srq: assert property ( // R2
        (CLS_I && no_evt_set) |=> !SRQ_O
    ) else $error("service request survived clear-status");

    a_cls_enables: assert property ( // R3
        (CLS_I && !EN_WR_I && !NV_RESTORE_I && !SHUTDOWN_I) |=> $stable(NV_ENABLES_O)
    ) else $error("clear-status changed an enable register");

    a_mav_pos: assert property ( // R19
        STB_O[stl_pkg::STB_MAV_BIT] == MAV_I
    ) else $error("message-available bit misplaced");

    a_rb_semi: assert property ( // R6
        RB_VALID_O |-> (RB_CHAR_O != stl_pkg::CHAR_SLASH)
    ) else $error("slash returned on read-back");

    a_empty_space: assert property ( // R8
        (idle && LIST_RD_I && !TRIG_I && !DEV_RST_I && lst.len == '0) |=>
            (RB_VALID_O && RB_LAST_O && RB_CHAR_O == stl_pkg::CHAR_SPACE)
    ) else $error("empty list did not read back as a space");

    a_nested_trig: assert property ( // R9
        list_err |=> (esr_r[stl_pkg::ESR_EXE_BIT] && erb_r[stl_pkg::ERB_LIST_ERR_BIT])
    ) else $error("nested trigger did not set both error flags");

    a_list_kept: assert property ( // R13
        (!idle && !DEV_RST_I) |=> $stable(lst.len)
    ) else $error("list length changed while the list ran");

    a_empty_trig: assert property ( // R21
        (idle && TRIG_I && !DEV_RST_I && lst.len == '0) |=> (TRIG_DONE_O && idle && !EXEC_VALID_O) ##1 !TRIG_DONE_O
    ) else $error("empty trigger misbehaved");

    a_read_clear: assert property ( // R20
        (EVT_RD_I && EVT_SEL_I == stl_pkg::EVT_SEL_A && EVT_SET_A_I == 8'h00) |=> (era_r == 8'h00)
    ) else $error("event register A not cleared by its query");

    a_shutdown_keep: assert property ( // R18
        (SHUTDOWN_I && !psc_r && !EN_WR_I && !NV_RESTORE_I) |=> $stable(NV_ENABLES_O)
    ) else $error("shutdown cleared enables without the flag");
endmodule

// *** tb/stl_host_model.sv ***
`timescale 1ns/1ns
module stl_host_model (
    input wire logic clk_i,     // system clock
    input wire logic rst_n_i,   // reset, active low
    input wire logic slow_i,    // stall every other cycle
    output logic exec_ready_o,  // parser accepts a character
    output logic rb_ready_o     // output buffer accepts a character
);
    logic phase_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end
    // opposite phases so each stream sees stalls at different moments
    assign exec_ready_o = ~slow_i | phase_r;
    assign rb_ready_o = ~slow_i | ~phase_r;
endmodule

// *** tb/stl_status_top_tb.sv ***
`timescale 1ns/1ns
module stl_status_top_tb;
    logic clk = 1'b0, rst_n = 1'b0, slow = 1'b0, dev_rst = 1'b0, cls = 1'b0, message_available_bit = 1'b0, ev_rd = 1'b0;
    logic en_wr_s = 1'b0, en_rd = 1'b0, psc_wr = 1'b0, psc_d = 1'b0, nv_rst = 1'b0, nv_psc = 1'b0, shut = 1'b0;
    logic def_st = 1'b0, def_v = 1'b0, trig = 1'b0, lrd = 1'b0, ex_rdy, rb_rdy, t_done, rb_done, t_done_w;
    logic [7:0] set_std = 8'h00, set_a = 8'h00, set_b = 8'h00, en_d = 8'h00, def_c = 8'h00, rd_data, stb;
    logic [7:0] ex_c, rb_c;
    logic [1:0] ev_sel = 2'h0;
    logic [2:0] en_sel = 3'h0;
    logic [39:0] nv_en = 40'h00_00_00_00_5A;
    logic rd_v, srq, individual_status_message, ex_v, ex_l, rb_v, rb_l, busy;
    string ex_s, rb_s;
    int failures = 0, checks_done = 0;
    always #2 clk = ~clk;
    stl_status_top stl_status_top_i (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .DEV_RST_I(dev_rst), .CLS_I(cls),
        .EVT_SET_STD_I(set_std), .EVT_SET_A_I(set_a), .EVT_SET_B_I(set_b), .MAV_I(message_available_bit), .EVT_RD_I(ev_rd),
        .EVT_SEL_I(ev_sel), .EN_WR_I(en_wr_s), .EN_RD_I(en_rd), .EN_SEL_I(en_sel), .EN_DATA_I(en_d),
        .PSC_WR_I(psc_wr), .PSC_DATA_I(psc_d), .NV_RESTORE_I(nv_rst), .NV_ENABLES_I(nv_en), .NV_PSC_I(nv_psc),
        .SHUTDOWN_I(shut), .DEF_START_I(def_st), .DEF_VALID_I(def_v), .DEF_CHAR_I(def_c), .TRIG_I(trig),
        .LIST_RD_I(lrd), .EXEC_READY_I(ex_rdy), .RB_READY_I(rb_rdy), .RD_DATA_O(rd_data), .RD_VALID_O(rd_v),
        .STB_O(stb), .SRQ_O(srq), .IST_O(individual_status_message), .PSC_O(), .NV_ENABLES_O(), .EXEC_VALID_O(ex_v),
        .EXEC_CHAR_O(ex_c), .EXEC_LAST_O(ex_l), .RB_VALID_O(rb_v), .RB_CHAR_O(rb_c), .RB_LAST_O(rb_l),
        .TRIG_DONE_O(t_done_w), .LIST_BUSY_O(busy));
    stl_host_model stl_host_model_i (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .exec_ready_o(ex_rdy),
        .rb_ready_o(rb_rdy));
    // handshakes are seen at the falling edge before the rising edge that takes them
    always @(negedge clk) begin
        if (ex_v === 1'b1 && ex_rdy === 1'b1) ex_s = $sformatf("%s%c", ex_s, ex_c);
        if (rb_v === 1'b1 && rb_rdy === 1'b1) begin
            rb_s = $sformatf("%s%c", rb_s, rb_c);
            if (rb_l === 1'b1) rb_done = 1'b1;
        end
        if (t_done_w === 1'b1) t_done = 1'b1;
    end
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chks(input string n, input string e, input string g);
        checks_done++;
        if (g != e) begin
            failures++;
            $display("FAIL %s expected '%s' seen '%s'", n, e, g);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    task automatic wait_for(ref logic f);
        for (int i = 0; i < 800 && f !== 1'b1; i++) @(negedge clk);
        if (f !== 1'b1) begin
            failures++;
            $display("FAIL wait expected done seen timeout");
            end_of_test();
        end
    endtask
    task automatic en_wr(input logic [2:0] sel, input logic [7:0] d);
        en_sel = sel;
        en_d = d;
        pulse(en_wr_s);
    endtask
    task automatic rd(input bit ev, input logic [2:0] sel, input logic [7:0] e, input string n);
        ev_sel = sel[1:0];
        en_sel = sel;
        if (ev) pulse(ev_rd);
        else pulse(en_rd);
        // the answer stands for one cycle after the edge that took the query
        chk8(n, e, rd_v === 1'b1 ? rd_data : 8'hXX);
    endtask
    task automatic def_list(input string s);
        pulse(def_st);
        for (int i = 0; i < s.len(); i++) begin
            def_v = 1'b1;
            def_c = s[i];
            @(negedge clk);
        end
        def_v = 1'b0;
    endtask
    task automatic lread(input string e);
        rb_s = "";
        rb_done = 1'b0;
        pulse(lrd);
        wait_for(rb_done);
        chks("list readback", e, rb_s);
    endtask
    task automatic trig_run(input string e);
        ex_s = "";
        t_done = 1'b0;
        pulse(trig);
        wait_for(t_done);
        chks("executed list", e, ex_s);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        for (int k = 0; k < 5; k++) rd(0, 3'(k), 8'h00, "enable after reset");
        for (int k = 0; k < 5; k++) en_wr(3'(k), 8'(17 * (k + 1)));
        en_wr(3'h5, 8'hFF);
        for (int k = 0; k < 5; k++) rd(0, 3'(k), 8'(17 * (k + 1)), "enable readback");
        rd(0, 3'h5, 8'h00, "unused enable");
        en_wr(3'h0, 8'h10);
        en_wr(3'h3, 8'h20);
        en_wr(3'h4, 8'h20);
        set_std = 8'h10;
        set_a = 8'h81;
        message_available_bit = 1'b1;
        @(negedge clk);
        set_std = 8'h00;
        set_a = 8'h00;
        chk8("status byte", 8'h70, stb);
        chk8("service and status", 8'h03, {6'h00, srq, individual_status_message});
        rd(1, 3'h1, 8'h81, "event A read");
        rd(1, 3'h1, 8'h00, "event A after read");
        pulse(cls);
        chk8("status after clear", 8'h10, stb);
        chk8("request after clear", 8'h00, {7'h00, srq});
        rd(0, 3'h0, 8'h10, "enable after clear");
        rd(0, 3'h3, 8'h20, "enable after clear");
        pulse(shut);
        rd(0, 3'h0, 8'h10, "enable kept at shutdown");
        psc_d = 1'b1;
        pulse(psc_wr);
        pulse(shut);
        rd(0, 3'h0, 8'h00, "enable cleared at shutdown");
        pulse(nv_rst);
        rd(0, 3'h0, 8'h5A, "enable restored");
        def_list("A/B");
        lread("A;B");
        slow = 1'b1;
        trig_run("A;B");
        lread("A;B");
        rd(1, 3'h0, 8'h00, "no error after run");
        pulse(dev_rst);
        lread(" ");
        trig_run("");
        rd(1, 3'h0, 8'h00, "empty trigger error");
        def_list("x*trg");
        trig_run("");
        rd(1, 3'h0, 8'h10, "nested trigger error");
        rd(1, 3'h2, 8'h08, "list error flag");
        lread("x*trg");
        trig_run("");
        rd(1, 3'h0, 8'h10, "error again");
        def_list({81{"U"}});
        rd(1, 3'h0, 8'h10, "overflow error");
        lread({80{"U"}});
        end_of_test();
    end
endmodule
